// ==== core/acd_audio_clock_divider.sv ====
// Audio clock divider: field-locked master clock synthesis, serial bit
// clock and channel clock division, AHB-Lite register slave.
// Assumes divider_clock_in and the vertical pulses are synchronous to clk
// and that divider_clock_in runs below half the clk rate.
// Wide values span several byte registers; software writes their parts
// one at a time, so the synthesiser briefly runs on a mixed value.
//
// Notes on behaviour
// - serial clock = input / (2 * (divisor + 1)).
// - channel clock = serial / (2 * channel divisor).
// - channel phase bit picks serial edge used.
// - serial phase bit picks input edge used.
// - vertical select: 0 internal, 1 external reference.
// - loop bit 0 closes slow lock, 1 opens.
// - closed loop keeps fixed clocks per field.
// - outputs master, serial and channel clocks.
// - divided clocks made by binary counting division.
// - 18-bit clocks-per-field over three registers.
// - 22-bit nominal increment over three registers.
// - emit clocks-per-field master clocks each field.
// - nominal increment steps the phase accumulator.
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module acd_audio_clock_divider (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        divider_clock_in,
  input  wire logic        vref_internal_in,
  input  wire logic        vref_external_in,
  output logic             master_audio_clock_out,
  output logic             serial_bit_clock_out,
  output logic             channel_select_clock_out
);
  import acd_pkg::*;

  logic [17:0] cpf_q;
  logic [21:0] inc_q;
  logic [5:0]  serial_clock_divisor_q;
  logic [5:0]  channel_clock_divisor_q;
  logic [3:0]  ctrl_q;
  logic [17:0] field_count_q;
  logic [17:0] last_count_q;
  logic        wr_pend_q;
  logic [7:0]  wr_idx_q;
  logic        div_restart_q;
  logic [31:0] rd_d;
  logic [7:0]  a_idx;
  logic        a_valid;
  logic [7:0]  wb;

  // SEQ is accepted too, although a single-transfer master never uses it.
  assign a_idx   = haddr[9:2];
  assign a_valid = hsel && hready &&
                   (htrans == ACD_HTRANS_NONSEQ || htrans == ACD_HTRANS_SEQ);
  assign wb      = hwdata[7:0];

  // Register writes land in the data phase, one cycle after the address.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else begin
      wr_pend_q <= a_valid && hwrite;
      wr_idx_q  <= a_idx;
    end
  end

  // Bits above a field's width are dropped on write, so they always read
  // back as zero and never reach the dividers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpf_q   <= ACD_CPF_RST;
      inc_q   <= ACD_INC_RST;
      serial_clock_divisor_q  <= ACD_SERIAL_CLOCK_DIVISOR_RST;
      channel_clock_divisor_q <= ACD_CHANNEL_CLOCK_DIVISOR_RST;
      ctrl_q  <= ACD_CTRL_RST;
    end else if (wr_pend_q) begin
      case (wr_idx_q)
        ACD_IDX_CPF_LO:  cpf_q[7:0]   <= wb;
        ACD_IDX_CPF_MID: cpf_q[15:8]  <= wb;
        ACD_IDX_CPF_HI:  cpf_q[17:16] <= wb[1:0];
        ACD_IDX_INC_LO:  inc_q[7:0]   <= wb;
        ACD_IDX_INC_MID: inc_q[15:8]  <= wb;
        ACD_IDX_INC_HI:  inc_q[21:16] <= wb[5:0];
        ACD_IDX_SERIAL_CLOCK_DIVISOR:    serial_clock_divisor_q       <= wb[5:0];
        ACD_IDX_CHANNEL_CLOCK_DIVISOR:   channel_clock_divisor_q      <= wb[5:0];
        ACD_IDX_CTRL:    ctrl_q       <= wb[3:0];
        default: ;
      endcase
    end
  end

  // A divisor write restarts both dividers from a clean phase.
  // The restart lands one clk after the new value, so the first period
  // after it already uses the new divisor.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_restart_q <= 1'b0;
    end else begin
      div_restart_q <= wr_pend_q && (wr_idx_q == ACD_IDX_SERIAL_CLOCK_DIVISOR ||
                                     wr_idx_q == ACD_IDX_CHANNEL_CLOCK_DIVISOR);
    end
  end

  // Read data is prepared from the address phase. A read right after a
  // write to the same register sees the byte being written.
  always_comb begin
    rd_d = 32'h0000_0000;
    case (a_idx)
      ACD_IDX_CPF_LO:  rd_d[7:0] = cpf_q[7:0];
      ACD_IDX_CPF_MID: rd_d[7:0] = cpf_q[15:8];
      ACD_IDX_CPF_HI:  rd_d[1:0] = cpf_q[17:16];
      ACD_IDX_INC_LO:  rd_d[7:0] = inc_q[7:0];
      ACD_IDX_INC_MID: rd_d[7:0] = inc_q[15:8];
      ACD_IDX_INC_HI:  rd_d[5:0] = inc_q[21:16];
      ACD_IDX_SERIAL_CLOCK_DIVISOR:    rd_d[5:0] = serial_clock_divisor_q;
      ACD_IDX_CHANNEL_CLOCK_DIVISOR:   rd_d[5:0] = channel_clock_divisor_q;
      ACD_IDX_CTRL:    rd_d[3:0] = ctrl_q;
      ACD_IDX_STATUS:  rd_d[17:0] = last_count_q;
      default:         rd_d = 32'h0000_0000;
    endcase
    if (wr_pend_q && wr_idx_q == a_idx) begin
      case (a_idx)
        ACD_IDX_CPF_LO,
        ACD_IDX_CPF_MID,
        ACD_IDX_INC_LO,
        ACD_IDX_INC_MID: rd_d[7:0] = wb;
        ACD_IDX_CPF_HI:  rd_d[7:0] = {6'h00, wb[1:0]};
        ACD_IDX_INC_HI,
        ACD_IDX_SERIAL_CLOCK_DIVISOR,
        ACD_IDX_CHANNEL_CLOCK_DIVISOR:   rd_d[7:0] = {2'h0, wb[5:0]};
        ACD_IDX_CTRL:    rd_d[7:0] = {4'h0, wb[3:0]};
        default:         ;
      endcase
    end
  end

  // Zero wait states: every transfer completes in its first data cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data is loaded only by a read's address phase, so it stands
  // through the data phase and beyond, until the next read.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h0000_0000;
    end else if (a_valid && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  // Master clock synthesis: a phase accumulator on the crystal clock.
  logic [22:0] acc_q;
  logic signed [11:0] corr_q;
  logic [22:0] step;
  logic        vref_q;
  logic        vref_sel;
  logic        field_edge;
  logic        mclk_rise;

  assign step = 23'(inc_q) + 23'(signed'(corr_q));
  assign vref_sel = ctrl_q[ACD_CTRL_VREF_BIT] ? vref_external_in
                                              : vref_internal_in;
  // A field starts at a rising edge of the selected vertical reference.
  assign field_edge = vref_sel && !vref_q;
  assign mclk_rise  = acc_q[22] && !master_audio_clock_out;

  // The top accumulator bit is the master clock, so its mean rate is the
  // step over two to the 23rd of the clk rate, with one clk of jitter.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q                  <= 23'h000000;
      master_audio_clock_out <= 1'b0;
    end else begin
      acc_q                  <= acc_q + step;
      master_audio_clock_out <= acc_q[22];
    end
  end

  // Master clock rises are counted between field starts; the last full
  // count is kept for software; the loop below compares the running count at each field start.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vref_q        <= 1'b0;
      field_count_q <= 18'h00000;
      last_count_q  <= 18'h00000;
    end else begin
      vref_q <= vref_sel;
      if (field_edge) begin
        last_count_q  <= field_count_q;
        field_count_q <= mclk_rise ? 18'h00001 : 18'h00000;
      end else if (mclk_rise) begin
        field_count_q <= field_count_q + 18'h00001;
      end
    end
  end

  // The loop nudges the step by one per field, so it is very slow and
  // never jerks the master clock; correction saturates at its range.
  // Opening the loop clears the correction, so the nominal step alone
  // sets the rate and software sees a predictable clock.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      corr_q <= 12'sh000;
    end else if (ctrl_q[ACD_CTRL_OPEN_BIT]) begin
      corr_q <= 12'sh000;
    end else if (field_edge) begin
      if (field_count_q < cpf_q && corr_q != 12'sh7FF) begin
        corr_q <= corr_q + 12'sh001;
      end else if (field_count_q > cpf_q && corr_q != 12'sh800) begin
        corr_q <= corr_q - 12'sh001;
      end
    end
  end

  // Serial bit clock: counts selected edges of the divider input.
  logic       dci_q;
  logic       dci_edge;
  logic [5:0] s_cnt_q;

  // Edges are found against the previous sample, so an input faster than
  // half the clk rate would lose edges and divide wrongly.
  assign dci_edge = ctrl_q[ACD_CTRL_SERIAL_EDGE_PHASE_BIT] ? (divider_clock_in && !dci_q)
                                              : (!divider_clock_in && dci_q);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dci_q                <= 1'b0;
      s_cnt_q              <= 6'h00;
      serial_bit_clock_out <= 1'b0;
    end else begin
      dci_q <= divider_clock_in;
      if (div_restart_q) begin
        s_cnt_q              <= 6'h00;
        serial_bit_clock_out <= 1'b0;
      end else if (dci_edge) begin
        if (s_cnt_q >= serial_clock_divisor_q) begin
          s_cnt_q              <= 6'h00;
          serial_bit_clock_out <= !serial_bit_clock_out;
        end else begin
          s_cnt_q <= s_cnt_q + 6'h01;
        end
      end
    end
  end

  // Channel clock: counts whole serial periods, one half per divisor.
  logic       sck_q;
  logic       sck_edge;
  logic [5:0] c_cnt_q;

  // Both phases watch the registered serial clock, so the channel clock
  // always trails its serial edge by one clk.
  assign sck_edge = ctrl_q[ACD_CTRL_CHANNEL_EDGE_PHASE_BIT]
                  ? (serial_bit_clock_out && !sck_q)
                  : (!serial_bit_clock_out && sck_q);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_q                    <= 1'b0;
      c_cnt_q                  <= 6'h00;
      channel_select_clock_out <= 1'b0;
    end else begin
      sck_q <= serial_bit_clock_out;
      // A zero channel divisor has no meaning; the clock is parked low.
      if (div_restart_q || channel_clock_divisor_q == 6'h00) begin
        c_cnt_q                  <= 6'h00;
        channel_select_clock_out <= 1'b0;
      end else if (sck_edge) begin
        if (c_cnt_q >= channel_clock_divisor_q - 6'h01) begin
          c_cnt_q                  <= 6'h00;
          channel_select_clock_out <= !channel_select_clock_out;
        end else begin
          c_cnt_q <= c_cnt_q + 6'h01;
        end
      end
    end
  end

endmodule : acd_audio_clock_divider
`default_nettype wire

// ==== core/acd_pkg.sv ====
// Constants shared by the audio clock divider: register indices, field
// positions, reset values and widths.
// Assumes a 250 MHz system clock that also serves as the crystal reference.
package acd_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] ACD_IDX_CPF_LO   = 8'h30;
  localparam logic [7:0] ACD_IDX_CPF_MID  = 8'h31;
  localparam logic [7:0] ACD_IDX_CPF_HI   = 8'h32;
  localparam logic [7:0] ACD_IDX_INC_LO   = 8'h34;
  localparam logic [7:0] ACD_IDX_INC_MID  = 8'h35;
  localparam logic [7:0] ACD_IDX_INC_HI   = 8'h36;
  localparam logic [7:0] ACD_IDX_SERIAL_CLOCK_DIVISOR     = 8'h38;
  localparam logic [7:0] ACD_IDX_CHANNEL_CLOCK_DIVISOR    = 8'h39;
  localparam logic [7:0] ACD_IDX_CTRL     = 8'h3A;
  localparam logic [7:0] ACD_IDX_STATUS   = 8'h3C;
  // Control register bit positions.
  localparam int ACD_CTRL_SERIAL_EDGE_PHASE_BIT = 0;
  localparam int ACD_CTRL_CHANNEL_EDGE_PHASE_BIT = 1;
  localparam int ACD_CTRL_VREF_BIT = 2;
  localparam int ACD_CTRL_OPEN_BIT = 3;
  // Field widths.
  localparam int ACD_CPF_W  = 18;
  localparam int ACD_INC_W  = 22;
  localparam int ACD_DIV_W  = 6;
  localparam int ACD_ACC_W  = 23;
  localparam int ACD_CORR_W = 12;
  // Reset values.
  localparam logic [17:0] ACD_CPF_RST   = 18'h3C000;
  localparam logic [21:0] ACD_INC_RST   = 22'h30FBCE;
  localparam logic [5:0]  ACD_SERIAL_CLOCK_DIVISOR_RST  = 6'h03;
  localparam logic [5:0]  ACD_CHANNEL_CLOCK_DIVISOR_RST = 6'h10;
  localparam logic [3:0]  ACD_CTRL_RST  = 4'h0;
  // AHB encodings.
  localparam logic [1:0]  ACD_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  ACD_HTRANS_SEQ    = 2'h3;
endpackage : acd_pkg

// ==== testbench/acd_codec_model.sv ====
// Codec-side model: supplies the clock to divide and times the clocks.
// Assumes clk is the bench clock; all times are in clk cycles.
`timescale 1ns/1ns
`default_nettype none
module acd_codec_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        sclk,
  input  wire logic        lclk,
  output logic             dclk,
  output logic      [15:0] sp,
  output logic      [15:0] cp,
  output logic      [15:0] ch,
  output logic             sl,
  output logic             cl
);
  logic [15:0] cyc_q, ts_q, tc_q;
  logic [1:0]  d_q;
  logic        s_q, c_q;
  // A half period of four cycles keeps input edges apart for the sampler.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {cyc_q, ts_q, tc_q, d_q, s_q, c_q, dclk, sp, cp, ch, sl, cl} <= '0;
    end else begin
      cyc_q <= cyc_q + 16'h1;
      d_q <= d_q + 2'h1;
      if (d_q == 2'h3) dclk <= !dclk;
      s_q <= sclk;
      c_q <= lclk;
      if (sclk != s_q) sl <= dclk;
      if (lclk != c_q) cl <= sclk;
      if (sclk && !s_q) begin
        sp <= cyc_q - ts_q;
        ts_q <= cyc_q;
      end
      if (lclk && !c_q) begin
        cp <= cyc_q - tc_q;
        tc_q <= cyc_q;
      end
      if (!lclk && c_q) ch <= cyc_q - tc_q;
    end
  end
endmodule : acd_codec_model
`default_nettype wire

// ==== testbench/acd_monitor.sv ====
// Port checker for the audio clock divider.
// Assumes divider input half periods of two clk cycles or more.
`timescale 1ns/1ns
`default_nettype none
module acd_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        divider_clock_in,
  input wire logic        master_audio_clock_out,
  input wire logic        serial_bit_clock_out,
  input wire logic        channel_select_clock_out
);
  logic [3:0] quiet_q;
  // Divisor writes restart the dividers, so edge checks pause after any write.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) quiet_q <= 4'h0;
    else if (hsel && hwrite) quiet_q <= 4'h0;
    else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
  end
  wire logic ok = quiet_q == 4'hF;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ready_high: assert property (hreadyout) else $error("not ready");
  a_resp_okay: assert property (!hresp) else $error("bad resp");
  a_rdata_top: assert property (hrdata[31:18] == 14'h0)
    else $error("rdata top");
  a_serial_gap: assert property (ok && $changed(serial_bit_clock_out)
    |=> $stable(serial_bit_clock_out)) else $error("serial gap");
  a_serial_cause: assert property (ok && $stable(divider_clock_in)[*5]
    |=> $stable(serial_bit_clock_out)) else $error("serial cause");
  a_chan_cause: assert property (ok && $stable(serial_bit_clock_out)[*5]
    |=> $stable(channel_select_clock_out)) else $error("chan cause");
  a_chan_gap: assert property (ok && $changed(channel_select_clock_out)
    |=> $stable(channel_select_clock_out)[*3]) else $error("chan gap");
  a_master_runs: assert property (ok
    |-> not ($stable(master_audio_clock_out)[*3])) else $error("master");
  a_reset_quiet: assert property ($rose(rst_b)
    |-> !serial_bit_clock_out && !channel_select_clock_out)
    else $error("reset clocks");
  c_chan: cover property (ok && $rose(channel_select_clock_out));
  c_read: cover property (hsel && !hwrite);
  c_write: cover property (hsel && hwrite);
endmodule : acd_monitor
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Bench: register access over AHB-Lite, clock timing, field counts.
// Assumes the package, design, checker and codec model compile first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import acd_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        vi = 1'b0, ve = 1'b0, hready, hresp, mclk, sclk, lclk;
  logic        dclk, sl, cl;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [15:0] sp, cp, ch;
  int          n_errors = 0, num_checks = 0;
  // Index, reset value and implemented bits of each register except status.
  logic [23:0] tbl [9] = '{24'h3000FF, 24'h31C0FF, 24'h320303, 24'h34CEFF,
    24'h35FBFF, 24'h36303F, 24'h38033F, 24'h39103F, 24'h3A000F};
  acd_audio_clock_divider dut (.clk, .rst_b, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready),
    .hresp, .divider_clock_in(dclk), .vref_internal_in(vi),
    .vref_external_in(ve), .master_audio_clock_out(mclk),
    .serial_bit_clock_out(sclk), .channel_select_clock_out(lclk));
  acd_codec_model codec (.clk, .rst_b, .sclk, .lclk, .dclk, .sp, .cp, .ch,
    .sl, .cl);
  initial forever #2 clk = ~clk;
  initial forever begin
    repeat (1000) @(posedge clk);
    vi <= 1'b1;
    @(posedge clk) vi <= 1'b0;
  end
  initial forever begin
    repeat (1600) @(posedge clk);
    ve <= 1'b1;
    @(posedge clk) ve <= 1'b0;
  end
  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] v, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= ACD_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] idx, v);
    logic [31:0] r;
    xfer(1'b1, idx, {24'h0, v}, r);
  endtask : wr
  task automatic rchk(input logic [7:0] idx, msk, exp);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h0, r);
    chk(r & {24'h0, msk}, {24'h0, exp}, "register");
  endtask : rchk
  task automatic fld(input logic [7:0] c, input int lo, hi);
    logic [31:0] r;
    wr(ACD_IDX_CTRL, c);
    repeat (3300) @(posedge clk);
    xfer(1'b0, ACD_IDX_STATUS, 32'h0, r);
    chk({31'h0, r >= lo && r <= hi}, 32'h1, "field count");
  endtask : fld
  task automatic ckt(input logic [5:0] s, l, input logic [1:0] ph);
    wr(ACD_IDX_CTRL, {6'h00, ph});
    wr(ACD_IDX_SERIAL_CLOCK_DIVISOR, {2'h0, s});
    wr(ACD_IDX_CHANNEL_CLOCK_DIVISOR, {2'h0, l});
    repeat (2) @(posedge clk);
    chk({30'h0, sclk, lclk}, 32'h0, "restart");
    repeat (96 * (s + 1) * l) @(posedge clk);
    chk({16'h0, sp}, 32'(16 * (s + 1)), "serial");
    chk({16'h0, cp}, 32'(32 * (s + 1) * l), "channel");
    chk({16'h0, ch}, 32'(16 * (s + 1) * l), "high");
    chk({31'h0, sl}, {31'h0, ph[0]}, "serial edge");
    chk({31'h0, cl}, {31'h0, ph[1]}, "channel edge");
    $display("clock test %0d %0d %0d done", s, l, ph);
  endtask : ckt
  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (tbl[i]) rchk(tbl[i][23:16], tbl[i][7:0], tbl[i][15:8]);
    $display("reset values done");
    fld(8'h08, 382, 384);
    fld(8'h04, 611, 614);
    $display("field counts done");
    foreach (tbl[i]) begin
      wr(tbl[i][23:16], 8'hA5);
      rchk(tbl[i][23:16], tbl[i][7:0], 8'hA5 & tbl[i][7:0]);
    end
    wr(8'h3B, 8'h5A);
    rchk(8'h3B, 8'hFF, 8'h00);
    $display("register access done");
    for (int p = 0; p < 4; p++) ckt(6'h01, 6'h02, p[1:0]);
    ckt(6'h00, 6'h01, 2'h3);
    ckt(6'h03, 6'h10, 2'h0);
    wr(ACD_IDX_CHANNEL_CLOCK_DIVISOR, 8'h00);
    repeat (300) @(posedge clk);
    chk({31'h0, lclk}, 32'h0, "channel held");
    $display("zero divisor done");
    results();
  end
  initial begin
    // The tests need about 15,000 cycles; this leaves ample margin.
    repeat (40000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule : tb_top
bind acd_audio_clock_divider acd_monitor mon (.clk, .rst_b, .hsel, .hwrite,
  .hrdata, .hreadyout, .hresp, .divider_clock_in, .master_audio_clock_out,
  .serial_bit_clock_out, .channel_select_clock_out);
`default_nettype wire
